// >>> rcs_pkg.sv
package rcs_pkg;

	// ------------------------------------------------------------
	// Widths and depths
	// ------------------------------------------------------------
	localparam int PC_W = 13;
	localparam int IW = 14;
	localparam int STK_DEPTH = 6;
	localparam int RAM_BYTES = 192;
	localparam logic [2:0] SP_LAST = 3'h5;

	// Vectors
	localparam logic [12:0] VEC_RESET = 13'h0000;
	localparam logic [12:0] VEC_IRQ = 13'h0001;

	// ------------------------------------------------------------
	// Status register layout, held fixed for firmware [RQ24]
	// ------------------------------------------------------------
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_BANK = 4;
	localparam int ST_PAGE = 6;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] FSR_RST = 8'h00;
	localparam logic [7:0] W_RST = 8'h00;

	// Flag mask bit positions
	localparam int FM_C = 0;
	localparam int FM_DC = 1;
	localparam int FM_Z = 2;

	// ------------------------------------------------------------
	// File plane map
	// ------------------------------------------------------------
	localparam logic [6:0] FA_IND = 7'h00;
	localparam logic [6:0] FA_PCL = 7'h02;
	localparam logic [6:0] FA_STATUS = 7'h03;
	localparam logic [6:0] FA_FSR = 7'h04;
	localparam logic [6:0] FA_RAM_BASE = 7'h20;
	localparam logic [7:0] RAM_BANK_OFF = 8'h60;

	// ------------------------------------------------------------
	// Instruction encoding
	// ------------------------------------------------------------
	localparam logic [13:0] OP_NOP = 14'h0000;
	localparam logic [1:0] CL_BYTE = 2'h0;
	localparam logic [1:0] CL_BITLIT = 2'h1;
	localparam logic [1:0] CL_CALL = 2'h2;
	localparam logic [1:0] CL_BRANCH_ABSOLUTE = 2'h3;
	localparam logic [6:0] LO_RET = 7'h40;
	localparam logic [6:0] LO_INTERRUPT_EXIT = 7'h60;
	localparam logic [6:0] LO_SLEEP = 7'h03;
	localparam logic [6:0] LO_WDT = 7'h04;
	localparam logic [3:0] BO_MISC = 4'h0, BO_CLR = 4'h1, BO_SUB = 4'h2, BO_DEC = 4'h3;
	localparam logic [3:0] BO_IOR = 4'h4, BO_AND = 4'h5, BO_XOR = 4'h6, BO_ADD = 4'h7;
	localparam logic [3:0] BO_MOV = 4'h8, BO_COM = 4'h9, BO_INC = 4'ha, BO_DECSZ = 4'hb;
	localparam logic [3:0] BO_RRF = 4'hc, BO_RLF = 4'hd, BO_SWAP = 4'he, BO_INCSZ = 4'hf;
	localparam logic [1:0] BT_CLR = 2'h0, BT_SET = 2'h1, BT_SKC = 2'h2, BT_SKS = 2'h3;
	localparam logic [2:0] LT_RET = 3'h0, LT_MOV = 3'h1, LT_IOR = 3'h2;
	localparam logic [2:0] LT_AND = 3'h3, LT_ADD = 3'h4, LT_XOR = 3'h7;

	// Instruction cycle phases
	typedef enum logic {PH_FIRST, PH_SECOND} rcs_ph_e;

	// ALU functions
	typedef enum logic [3:0] {
		AO_ADD, AO_SUB, AO_INC, AO_DEC, AO_OR, AO_AND, AO_XOR,
		AO_COM, AO_RR, AO_RL, AO_SWAP, AO_PASS, AO_PASSW, AO_ZERO
	} rcs_alu_e;

endpackage : rcs_pkg

// >>> rcs_stack_if.sv
// Return stack request and answer
interface rcs_stack_if;
	logic push;
	logic pop;
	logic [12:0] wdata;
	logic [12:0] top;
	modport ctl (output push, output pop, output wdata, input top);
	modport stk (input push, input pop, input wdata, output top);
endinterface : rcs_stack_if

// >>> rcs_alu.sv
module rcs_alu (
	// Function select
	input wire rcs_pkg::rcs_alu_e op,
	// Operands
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic cin,
	// Result and flags
	output logic [7:0] res,
	output logic c_out,
	output logic dc_out,
	output logic z_out
);
	logic [8:0] sum;
	logic [4:0] nib;

	// Eight-bit add, subtract, shift and logic [RQ15]
	always_comb begin
		sum = 9'h000;
		nib = 5'h00;
		res = a;
		c_out = cin;
		dc_out = 1'b0;
		unique case (op)
			rcs_pkg::AO_ADD: begin
				sum = {1'b0, a} + {1'b0, b};
				nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
				res = sum[7:0];
				c_out = sum[8];
				dc_out = nib[4];
			end
			rcs_pkg::AO_SUB: begin
				// Carry out of a + ~b + 1 is high when nothing was borrowed [RQ18]
				sum = {1'b0, a} + {1'b0, ~b} + 9'h001;
				nib = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
				res = sum[7:0];
				c_out = sum[8];
				dc_out = nib[4];
			end
			rcs_pkg::AO_INC: res = a + 8'h01;
			rcs_pkg::AO_DEC: res = a - 8'h01;
			rcs_pkg::AO_OR: res = a | b;
			rcs_pkg::AO_AND: res = a & b;
			rcs_pkg::AO_XOR: res = a ^ b;
			rcs_pkg::AO_COM: res = ~a;
			rcs_pkg::AO_RR: begin
				res = {cin, a[7:1]};
				c_out = a[0];
			end
			rcs_pkg::AO_RL: begin
				res = {a[6:0], cin};
				c_out = a[7];
			end
			rcs_pkg::AO_SWAP: res = {a[3:0], a[7:4]};
			rcs_pkg::AO_PASS: res = a;
			rcs_pkg::AO_PASSW: res = b;
			rcs_pkg::AO_ZERO: res = 8'h00;
			default: res = a;
		endcase
		z_out = (res == 8'h00);
	end

endmodule : rcs_alu

// >>> rcs_stack.sv
module rcs_stack (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Stack port
	rcs_stack_if.stk sif
);
	logic [2:0] sp_q, sp_d;
	logic [12:0] mem_q [0:rcs_pkg::STK_DEPTH-1];
	logic [12:0] mem_d [0:rcs_pkg::STK_DEPTH-1];
	logic [2:0] sp_prev;

	// Six entries of thirteen bits, circular so an overflow drops the oldest [RQ9]
	always_comb begin
		sp_prev = (sp_q == 3'h0) ? rcs_pkg::SP_LAST : sp_q - 3'h1;
		sp_d = sp_q;
		mem_d = mem_q;
		if (sif.push) begin
			mem_d[sp_q] = sif.wdata; // [RQ10]
			sp_d = (sp_q == rcs_pkg::SP_LAST) ? 3'h0 : sp_q + 3'h1;
		end else if (sif.pop) begin
			sp_d = sp_prev; // [RQ10]
		end
	end

	assign sif.top = mem_q[sp_prev];

	// Stack registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sp_q <= 3'h0;
			for (int i = 0; i < rcs_pkg::STK_DEPTH; i++) begin
				mem_q[i] <= rcs_pkg::VEC_RESET;
			end
		end else if (clk_en) begin
			sp_q <= sp_d;
			mem_q <= mem_d;
		end
	end

endmodule : rcs_stack

// >>> rcs_core.sv
// Overview of operation
// [RQ1] - Crystal clock halved: each instruction cycle is a first and a second phase.
// [RQ2] - Counter moves in first phase; instruction latched in second, executed next cycle.
// [RQ3] - Program counter is 13 bits, addressing 8K words of 14 bits.
// [RQ4] - Counter steps by one unless branch, return, reset or interrupt redirects it.
// [RQ5] - Reset starts at address 0; interrupt service starts at address 1.
// [RQ6] - Call and branch load low 12 bits from instruction, top from page bit.
// [RQ7] - Every return kind reloads the counter from the stack top.
// [RQ8] - Other writes of the counter low byte keep bits 12 to 8.
// [RQ9] - Return stack holds six entries of 13 bits.
// [RQ10] - Calls and interrupts push, returns pop, last in first out.
// [RQ11] - Write-only plane is written only by storing the accumulator directly.
// [RQ12] - File plane direct or indirect; address 0 uses the file select pointer.
// [RQ13] - Bit set, clear and test reach file addresses 00 to 3f.
// [RQ14] - 00 to 1f are registers; 20 to 7f banked by status bit 4.
// [RQ15] - Eight-bit ALU does add, subtract, shift and logic.
// [RQ16] - Accumulator is unaddressed, paired with a file register or a literal.
// [RQ17] - ALU updates carry, nibble carry and zero flags per instruction.
// [RQ18] - In subtraction carry and nibble carry mean no borrow.
// [RQ19] - Status register is a legal destination like any file register.
// [RQ20] - Flag instructions targeting status keep flag bits from the write; flag logic wins.
// [RQ21] - Firmware should alter status only with bit clear, bit set or store.
// [RQ22] - Interrupt taken at cycle end: call to 1, in-service flag blocks nesting.
// [RQ23] - Instructions take one cycle; program branches take two.
// [RQ24] - Flag positions in status are fixed and documented.
module rcs_core (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Program store
	output logic [12:0] rom_addr,
	input wire logic [13:0] rom_data,
	// Low file registers 01 and 05 to 1f outside the core
	output logic [6:0] sfr_addr,
	output logic [7:0] sfr_wdata,
	output logic sfr_we,
	input wire logic [7:0] sfr_rdata,
	// Write-only plane
	output logic [5:0] wp_addr,
	output logic [7:0] wp_data,
	output logic wp_we,
	// Interrupt
	input wire logic irq_req,
	output logic in_service
);
	rcs_pkg::rcs_ph_e phase_q, phase_d;
	logic [12:0] pc_q, pc_d, pcn_q, pcn_d;
	logic [13:0] ir_q, ir_d;
	logic iflag_q, iflag_d, clrp_q, clrp_d;
	logic [6:0] sfa_q, sfa_d;
	logic [7:0] w_q, w_d, status_q, status_d, fsr_q, fsr_d;
	logic [7:0] sfr_wdata_q, sfr_wdata_d, wp_data_q, wp_data_d;
	logic sfr_we_q, sfr_we_d, wp_we_q, wp_we_d;
	logic [5:0] wp_addr_q, wp_addr_d;
	logic [7:0] ram_q [0:rcs_pkg::RAM_BYTES-1];
	logic ram_we;
	logic [7:0] ridx;

	// Decode outputs
	// Decode packs the function with its flag mask, so it is kept as a plain vector
	logic [3:0] alu_op;
	rcs_pkg::rcs_alu_e alu_fn;
	logic use_lit, wr_f, wr_w, call, br, ret, interrupt_exit, skip_z, bitw, bskip, store_to_write_plane;
	logic [2:0] fmask;
	logic [6:0] raw_fa, fa;
	logic [7:0] fv, alu_a, alu_res, bv, rv;
	logic alu_c, alu_dc, alu_z;
	logic sec, exec, skip, pcl_wr, redirect, irq_go;

	rcs_stack_if sif ();

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	assign sec = (phase_q == rcs_pkg::PH_SECOND);
	assign exec = clk_en && sec;

	// Field split by instruction class
	always_comb begin
		alu_op = rcs_pkg::AO_PASS;
		{use_lit, wr_f, wr_w, call, br, ret, interrupt_exit, skip_z, bitw, bskip, store_to_write_plane} = 11'h000;
		fmask = 3'h0;
		unique case (ir_q[13:12])
			rcs_pkg::CL_CALL: call = 1'b1;
			rcs_pkg::CL_BRANCH_ABSOLUTE: br = 1'b1;
			rcs_pkg::CL_BITLIT: begin
				if (ir_q[11]) begin
					use_lit = 1'b1;
					wr_w = 1'b1; // [RQ16]
					case (ir_q[10:8])
						rcs_pkg::LT_RET: ret = 1'b1;
						rcs_pkg::LT_MOV: alu_op = rcs_pkg::AO_PASS;
						rcs_pkg::LT_IOR: {alu_op, fmask} = {rcs_pkg::AO_OR, 3'h4};
						rcs_pkg::LT_AND: {alu_op, fmask} = {rcs_pkg::AO_AND, 3'h4};
						rcs_pkg::LT_ADD: {alu_op, fmask} = {rcs_pkg::AO_ADD, 3'h7};
						rcs_pkg::LT_XOR: {alu_op, fmask} = {rcs_pkg::AO_XOR, 3'h4};
						default: wr_w = 1'b0; // Unused literal codes act as no operation
					endcase
				end else begin
					// Bit field names one of 00 to 3f only [RQ13]
					unique case (ir_q[10:9])
						rcs_pkg::BT_CLR, rcs_pkg::BT_SET: begin
							bitw = 1'b1;
							wr_f = 1'b1;
						end
						rcs_pkg::BT_SKC: bskip = !fv[ir_q[8:6]];
						rcs_pkg::BT_SKS: bskip = fv[ir_q[8:6]];
					endcase
				end
			end
			rcs_pkg::CL_BYTE: begin
				wr_f = ir_q[7];
				wr_w = !ir_q[7];
				unique case (ir_q[11:8])
					rcs_pkg::BO_MISC: begin
						wr_w = 1'b0;
						alu_op = rcs_pkg::AO_PASSW;
						ret = !ir_q[7] && (ir_q[6:0] == rcs_pkg::LO_RET || ir_q[6:0] == rcs_pkg::LO_INTERRUPT_EXIT);
						interrupt_exit = !ir_q[7] && ir_q[6:0] == rcs_pkg::LO_INTERRUPT_EXIT;
						store_to_write_plane = !ir_q[7] && !ir_q[6] && ir_q[6:0] != 7'h00
							&& ir_q[6:0] != rcs_pkg::LO_SLEEP && ir_q[6:0] != rcs_pkg::LO_WDT;
					end
					rcs_pkg::BO_CLR: {alu_op, fmask} = {rcs_pkg::AO_ZERO, 3'h4};
					rcs_pkg::BO_SUB: {alu_op, fmask} = {rcs_pkg::AO_SUB, 3'h7};
					rcs_pkg::BO_DEC: {alu_op, fmask} = {rcs_pkg::AO_DEC, 3'h4};
					rcs_pkg::BO_IOR: {alu_op, fmask} = {rcs_pkg::AO_OR, 3'h4};
					rcs_pkg::BO_AND: {alu_op, fmask} = {rcs_pkg::AO_AND, 3'h4};
					rcs_pkg::BO_XOR: {alu_op, fmask} = {rcs_pkg::AO_XOR, 3'h4};
					rcs_pkg::BO_ADD: {alu_op, fmask} = {rcs_pkg::AO_ADD, 3'h7};
					rcs_pkg::BO_MOV: begin
						// Set d bit is the zero test with no write
						wr_f = 1'b0;
						fmask = ir_q[7] ? 3'h4 : 3'h0;
					end
					rcs_pkg::BO_COM: {alu_op, fmask} = {rcs_pkg::AO_COM, 3'h4};
					rcs_pkg::BO_INC: {alu_op, fmask} = {rcs_pkg::AO_INC, 3'h4};
					rcs_pkg::BO_DECSZ: {alu_op, skip_z} = {rcs_pkg::AO_DEC, 1'b1};
					rcs_pkg::BO_RRF: {alu_op, fmask} = {rcs_pkg::AO_RR, 3'h1};
					rcs_pkg::BO_RLF: {alu_op, fmask} = {rcs_pkg::AO_RL, 3'h1};
					rcs_pkg::BO_SWAP: alu_op = rcs_pkg::AO_SWAP;
					rcs_pkg::BO_INCSZ: {alu_op, skip_z} = {rcs_pkg::AO_INC, 1'b1};
				endcase
			end
		endcase
	end

	// ------------------------------------------------------------
	// File plane access
	// ------------------------------------------------------------
	// Address 0 goes through the pointer [RQ12]
	assign raw_fa = (ir_q[13:12] == rcs_pkg::CL_BITLIT) ? {1'b0, ir_q[5:0]} : ir_q[6:0];
	assign fa = (raw_fa == rcs_pkg::FA_IND) ? fsr_q[6:0] : raw_fa;
	// 20 to 7f land in the bank chosen by the bank bit [RQ14]
	assign ridx = ({1'b0, fa} - {1'b0, rcs_pkg::FA_RAM_BASE})
		+ (status_q[rcs_pkg::ST_BANK] ? rcs_pkg::RAM_BANK_OFF : 8'h00);

	// Read mux; low addresses are registers whatever the bank [RQ14]
	always_comb begin
		if (fa >= rcs_pkg::FA_RAM_BASE) begin
			fv = ram_q[ridx];
		end else begin
			case (fa)
				rcs_pkg::FA_IND: fv = 8'h00; // Pointer aimed at itself reads zero
				rcs_pkg::FA_PCL: fv = pc_q[7:0];
				rcs_pkg::FA_STATUS: fv = status_q;
				rcs_pkg::FA_FSR: fv = fsr_q;
				default: fv = sfr_rdata;
			endcase
		end
	end

	assign alu_a = use_lit ? ir_q[7:0] : fv;
	assign alu_fn = rcs_pkg::rcs_alu_e'(alu_op);

	rcs_alu u_alu (
		.op(alu_fn),
		.a(alu_a),
		.b(w_q),
		.cin(status_q[rcs_pkg::ST_C]),
		.res(alu_res),
		.c_out(alu_c),
		.dc_out(alu_dc),
		.z_out(alu_z)
	);

	// Bit clear and set rewrite one bit of the file value
	always_comb begin
		bv = fv;
		bv[ir_q[8:6]] = (ir_q[10:9] == rcs_pkg::BT_SET);
	end

	assign rv = bitw ? bv : alu_res;
	assign skip = bskip || (skip_z && alu_z);
	assign pcl_wr = wr_f && fa == rcs_pkg::FA_PCL;
	assign redirect = call || br || ret || pcl_wr;
	// A skip or redirect would make the pushed address wrong, so wait one cycle [RQ22]
	assign irq_go = sec && irq_req && !iflag_q && !redirect && !skip;

	// Stack requests [RQ10]
	assign sif.push = sec && (call || irq_go);
	assign sif.pop = sec && ret;
	assign sif.wdata = pc_q;

	rcs_stack u_stack (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.sif(sif)
	);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// Next phase, counter, instruction and in-service flag
	always_comb begin
		phase_d = sec ? rcs_pkg::PH_FIRST : rcs_pkg::PH_SECOND; // [RQ1]
		{pc_d, pcn_d, ir_d, sfa_d} = {pc_q, pcn_q, ir_q, sfa_q};
		iflag_d = iflag_q;
		clrp_d = clrp_q;
		if (!sec) begin
			pc_d = pcn_q; // [RQ2] [RQ3]
			sfa_d = fa;
		end else begin
			// Fetched word is dropped behind a redirect, giving branches two cycles
			ir_d = (redirect || skip || irq_go) ? rcs_pkg::OP_NOP : rom_data; // [RQ2] [RQ23]
			pcn_d = pc_q + 13'h0001; // [RQ4]
			if (call || br) begin
				pcn_d = {status_q[rcs_pkg::ST_PAGE], ir_q[11:0]}; // [RQ6]
			end
			if (ret) begin
				pcn_d = sif.top; // [RQ7]
			end
			if (pcl_wr) begin
				pcn_d = {pc_q[12:8], rv}; // [RQ8]
			end
			// In-service clears one instruction after the interrupt exit
			clrp_d = interrupt_exit;
			if (clrp_q) begin
				iflag_d = 1'b0;
			end
			if (irq_go) begin
				pcn_d = rcs_pkg::VEC_IRQ; // [RQ5] [RQ22]
				iflag_d = 1'b1; // [RQ22]
			end
		end
	end

	// Sequencer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= rcs_pkg::PH_FIRST;
			pc_q <= rcs_pkg::VEC_RESET; // [RQ5]
			pcn_q <= rcs_pkg::VEC_RESET;
			ir_q <= rcs_pkg::OP_NOP;
			iflag_q <= 1'b0;
			clrp_q <= 1'b0;
			sfa_q <= rcs_pkg::FA_IND;
		end else if (clk_en) begin
			phase_q <= phase_d;
			pc_q <= pc_d;
			pcn_q <= pcn_d;
			ir_q <= ir_d;
			iflag_q <= iflag_d;
			clrp_q <= clrp_d;
			sfa_q <= sfa_d;
		end
	end

	// ------------------------------------------------------------
	// Datapath
	// ------------------------------------------------------------
	// Results land at the end of the second phase
	always_comb begin
		{w_d, status_d, fsr_d} = {w_q, status_q, fsr_q};
		{sfr_wdata_d, wp_data_d, wp_addr_d} = {sfr_wdata_q, wp_data_q, wp_addr_q};
		{sfr_we_d, wp_we_d, ram_we} = 3'h0;
		if (sec) begin
			if (wr_w) begin
				w_d = ret ? ir_q[7:0] : rv; // [RQ16]
			end
			if (wr_f) begin
				if (fa >= rcs_pkg::FA_RAM_BASE) begin
					ram_we = 1'b1;
				end else if (fa == rcs_pkg::FA_STATUS) begin
					status_d = rv; // [RQ19]
				end else if (fa == rcs_pkg::FA_FSR) begin
					fsr_d = rv;
				end else if (fa != rcs_pkg::FA_IND && fa != rcs_pkg::FA_PCL) begin
					sfr_we_d = 1'b1;
					sfr_wdata_d = rv;
				end
			end
			// Flag instructions never write the three flag bits directly [RQ20]
			if (fmask != 3'h0 && wr_f && fa == rcs_pkg::FA_STATUS) begin
				status_d[rcs_pkg::ST_C] = status_q[rcs_pkg::ST_C];
				status_d[rcs_pkg::ST_DC] = status_q[rcs_pkg::ST_DC];
				status_d[rcs_pkg::ST_Z] = status_q[rcs_pkg::ST_Z];
			end
			if (fmask[rcs_pkg::FM_C]) status_d[rcs_pkg::ST_C] = alu_c; // [RQ17] [RQ18]
			if (fmask[rcs_pkg::FM_DC]) status_d[rcs_pkg::ST_DC] = alu_dc; // [RQ17] [RQ18]
			if (fmask[rcs_pkg::FM_Z]) status_d[rcs_pkg::ST_Z] = alu_z; // [RQ17]
			if (store_to_write_plane) begin
				wp_we_d = 1'b1; // [RQ11]
				wp_addr_d = ir_q[5:0];
				wp_data_d = w_q;
			end
		end
	end

	// Datapath registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			w_q <= rcs_pkg::W_RST;
			status_q <= rcs_pkg::STATUS_RST;
			fsr_q <= rcs_pkg::FSR_RST;
			sfr_wdata_q <= 8'h00;
			sfr_we_q <= 1'b0;
			wp_addr_q <= 6'h00;
			wp_data_q <= 8'h00;
			wp_we_q <= 1'b0;
		end else if (clk_en) begin
			w_q <= w_d;
			status_q <= status_d;
			fsr_q <= fsr_d;
			sfr_wdata_q <= sfr_wdata_d;
			sfr_we_q <= sfr_we_d;
			wp_addr_q <= wp_addr_d;
			wp_data_q <= wp_data_d;
			wp_we_q <= wp_we_d;
		end
	end

	// Banked RAM holds data only, so it carries no reset
	always_ff @(posedge clk) begin
		if (clk_en && ram_we) begin
			ram_q[ridx] <= rv;
		end
	end

	// Outputs
	assign rom_addr = pc_q;
	assign sfr_addr = sfa_q;
	assign sfr_wdata = sfr_wdata_q;
	assign sfr_we = sfr_we_q;
	assign wp_addr = wp_addr_q;
	assign wp_data = wp_data_q;
	assign wp_we = wp_we_q;
	assign in_service = iflag_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_phase_alternate: assert property ( // [RQ1]
		clk_en |=> phase_q != $past(phase_q)) else $error("phase did not alternate");
	a_pc_first_only: assert property ( // [RQ2]
		$changed(pc_q) |-> $past(phase_q) == rcs_pkg::PH_FIRST && $past(clk_en))
		else $error("counter moved outside first phase");
	a_pc_step_one: assert property ( // [RQ4]
		exec && !redirect && !irq_go
		|=> pcn_q == $past(pc_q) + 13'h0001 ##1 !$past(clk_en) || pc_q == $past(pcn_q))
		else $error("counter did not step by one");
	a_irq_vector: assert property ( // [RQ5] [RQ22]
		exec && irq_go |=> pcn_q == rcs_pkg::VEC_IRQ && iflag_q && ir_q == rcs_pkg::OP_NOP)
		else $error("interrupt entry wrong");
	a_call_target: assert property ( // [RQ6]
		exec && (call || br) |=> pcn_q == {$past(status_q[rcs_pkg::ST_PAGE]), $past(ir_q[11:0])})
		else $error("branch target wrong");
	a_ret_target: assert property ( // [RQ7]
		exec && ret |=> pcn_q == $past(sif.top)) else $error("return target wrong");
	a_pcl_keep_high: assert property ( // [RQ8]
		exec && pcl_wr |=> pcn_q[12:8] == $past(pc_q[12:8])) else $error("counter high bits changed");
	a_branch_flush: assert property ( // [RQ23]
		exec && (call || br || ret) |=> ir_q == rcs_pkg::OP_NOP) else $error("branch not two cycles");
	a_sub_no_borrow: assert property ( // [RQ18]
		exec && alu_op == rcs_pkg::AO_SUB |=> status_q[rcs_pkg::ST_C] == ($past(alu_a) >= $past(w_q)))
		else $error("subtract carry wrong");
	a_flag_override: assert property ( // [RQ20]
		exec && fmask == 3'h4 && wr_f && fa == rcs_pkg::FA_STATUS
		|=> status_q[rcs_pkg::ST_Z] == $past(alu_z) && status_q[rcs_pkg::ST_C] == $past(status_q[rcs_pkg::ST_C]))
		else $error("flag write not suppressed");
	a_write_plane: assert property ( // [RQ11]
		exec && store_to_write_plane |=> wp_we && wp_data == $past(w_q) && wp_addr == $past(ir_q[5:0]))
		else $error("write plane store wrong");

	c_call: cover property (exec && call);
	c_irq_taken: cover property (exec && irq_go);
	c_return: cover property (exec && interrupt_exit);
	c_skip: cover property (exec && skip);

endmodule : rcs_core

// >>> rcs_mem_model.sv
module rcs_mem_model (
	// Clock
	input wire logic clk,
	input wire logic clk_en,
	// Program store
	input wire logic [12:0] rom_addr,
	output logic [13:0] rom_data,
	// Low file registers 01 to 1f
	input wire logic [6:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_we,
	output logic [7:0] sfr_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [13:0] rom [0:8191];
	logic [7:0] sfr [0:31];

	// Same-cycle reads; nothing answers above 1f, so show a moving pattern
	assign rom_data = rom[rom_addr];
	assign sfr_rdata = (sfr_addr < 7'h20) ? sfr[sfr_addr[4:0]] : ~rom_addr[7:0];

	// Writes land only on enabled edges, as the core's pulse does
	always @(posedge clk) begin
		if (clk_en && sfr_we) begin
			sfr[sfr_addr[4:0]] <= sfr_wdata;
		end
	end

	// Empty program space reads as no-operation
	initial begin
		for (int i = 0; i < 8192; i++) begin
			rom[i] = 14'h0000;
		end
		for (int i = 0; i < 32; i++) begin
			sfr[i] = 8'h00;
		end
	end
endmodule : rcs_mem_model

// >>> risc_core_sequencer_alu_tb_top.sv
module risc_core_sequencer_alu_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Signals and bench state
	// ------------------------------------------------------------
	logic clk, rst_n, clk_en, irq_req, sfr_we, wp_we, in_service;
	logic [12:0] rom_addr;
	logic [13:0] rom_data;
	logic [6:0] sfr_addr;
	logic [7:0] sfr_wdata, sfr_rdata, wp_data;
	logic [5:0] wp_addr;
	logic [7:0] a, b, c, d, e, k1, k2, s, r, st;
	logic [13:0] prog[$];
	logic [15:0] exp_q[$];
	int n_fail, cmp_count, i;

	rcs_core i_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .rom_addr(rom_addr),
		.rom_data(rom_data), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we),
		.sfr_rdata(sfr_rdata), .wp_addr(wp_addr), .wp_data(wp_data), .wp_we(wp_we),
		.irq_req(irq_req), .in_service(in_service));
	rcs_mem_model i_mem (.clk(clk), .clk_en(clk_en), .rom_addr(rom_addr), .rom_data(rom_data),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_rdata(sfr_rdata));

	always #2 clk = ~clk;

	// ------------------------------------------------------------
	// Compare and closing tasks
	// ------------------------------------------------------------
	task automatic stop_test;
		$display("n_fail=%0d cmp_count=%0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	task automatic chk_val(input logic [15:0] got, input logic [15:0] want);
		cmp_count++;
		if (got !== want) begin
			n_fail++;
			$display("BAD %0t value got %h want %h", $time, got, want);
		end
	endtask : chk_val

	// Each write-plane store is matched against the bench's expected queue, in order
	task automatic chk_wp(input logic [15:0] got);
		logic [15:0] want;
		want = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
		chk_val(got, want);
	endtask : chk_wp

	// Store pulse counts only on an enabled edge
	always @(posedge clk) begin
		if (rst_n && clk_en && wp_we === 1'b1) begin
			chk_wp({2'h0, wp_addr, wp_data});
		end
	end

	// Random stalls exercise the enable freeze
	always @(negedge clk) begin
		if (rst_n) begin
			clk_en <= ($urandom % 4) != 0;
		end
	end

	// Watchdog sized well beyond the program's run time
	initial begin
		repeat (30000) @(posedge clk);
		n_fail++;
		stop_test;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 0;
		rst_n = 0;
		clk_en = 1;
		irq_req = 0;
		void'($urandom(32'h8cbce2e7));
		{a, b, c, d, e, k1, k2} = 56'({$urandom, $urandom});
		// Let the store model clear its arrays before the program is loaded
		#1;
		s = a + b;
		r = s - c;
		st = 8'h00;
		st[rcs_pkg::ST_C] = s >= c;
		st[rcs_pkg::ST_DC] = s[3:0] >= c[3:0];
		st[rcs_pkg::ST_Z] = r == 8'h00;
		// Vectors, interrupt service, main program, nested subroutines
		i_mem.rom[0] = 14'h3010;
		i_mem.rom[1] = 14'h000b;
		i_mem.rom[2] = 14'h0060;
		// Status bank bit altered only by bit set and clear below
		prog = '{14'h1900 | a, 14'h0001, 14'h1c00 | b, 14'h0002, 14'h0085, 14'h1900 | c,
			14'h0205, 14'h0005, 14'h0803, 14'h0006, 14'h1905, 14'h0084, 14'h0800, 14'h0007,
			14'h1303, 14'h1900 | d, 14'h00a0, 14'h1103, 14'h1900 | e, 14'h00a0, 14'h1303,
			14'h0820, 14'h0008, 14'h1103, 14'h0820, 14'h000c, 14'h2040, 14'h0009, 14'h302c};
		foreach (prog[j]) begin
			i_mem.rom[13'h0010 + j] = prog[j];
		end
		i_mem.rom[13'h0040] = 14'h2050;
		i_mem.rom[13'h0041] = 14'h000a;
		i_mem.rom[13'h0042] = 14'h1800 | k2;
		i_mem.rom[13'h0050] = 14'h1800 | k1;
		exp_q = '{{8'h01, a}, {8'h02, s}, {8'h05, r}, {8'h06, st}, {8'h07, s}, {8'h08, d},
			{8'h0c, e}, {8'h0a, k1}, {8'h09, k2}, {8'h0b, k2}};
		repeat (20) @(negedge clk);
		chk_val({3'h0, rom_addr}, 16'h0000);
		rst_n = 1;
		for (i = 0; i < 3000 && exp_q.size() > 1; i++) @(negedge clk);
		// Level request while looping: service stores W from address 1
		irq_req = 1;
		for (i = 0; i < 200 && in_service !== 1'b1; i++) @(negedge clk);
		chk_val({15'h0, in_service}, 16'h0001);
		irq_req = 0;
		for (i = 0; i < 400 && (in_service !== 1'b0 || exp_q.size() > 0); i++) @(negedge clk);
		chk_val({15'h0, in_service}, 16'h0000);
		chk_val(16'(exp_q.size()), 16'h0000);
		stop_test;
	end
endmodule : risc_core_sequencer_alu_tb_top
